// [verilog/rtcv_pkg.sv]
package rtcv_pkg;

    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam int CLOCK_PERIOD_NS = 20;            // 50 MHz system clock
    localparam int OSC_START_MAX_S = 1;             // Longest oscillator start after enable, seconds
    localparam int IRQ_RELEASE_RD_MAX_US = 2;       // Longest interrupt release after read strobe high
    localparam int IRQ_RELEASE_RST_MAX_US = 2;      // Longest interrupt release after reset pin low
    // Longest times round down to whole cycles
    localparam int IRQ_RELEASE_RD_CYC = (IRQ_RELEASE_RD_MAX_US * 1000) / CLOCK_PERIOD_NS;
    localparam int IRQ_RELEASE_RST_CYC = (IRQ_RELEASE_RST_MAX_US * 1000) / CLOCK_PERIOD_NS;
    localparam longint OSC_START_CYC = (longint'(OSC_START_MAX_S) * 1000000000) / CLOCK_PERIOD_NS;
    localparam int SYNC_STAGES = 2;                 // Flops on every pin input

    // ==========================================================
    // Register offsets on the six address pins
    // ==========================================================
    localparam logic [5:0] OFS_CTRL_A = 6'h0A;      // Divider and rate select
    localparam logic [5:0] OFS_CTRL_B = 6'h0B;      // Interrupt enables and modes
    localparam logic [5:0] OFS_FLAGS = 6'h0C;       // Interrupt flags, cleared by read
    localparam logic [5:0] OFS_BATTERY_VALID_STATUS = 6'h0D; // Backup source health

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int A_RATE_LSB = 0;                  // rate_select_bits [3:0]
    localparam int A_DIV_LSB = 4;                   // divider_control_bits [6:4]
    localparam int B_DSE_BIT = 0;
    localparam int B_HOUR24_BIT = 1;
    localparam int B_DM_BIT = 2;
    localparam int B_SQWE_BIT = 3;
    localparam int B_UIE_BIT = 4;
    localparam int B_AIE_BIT = 5;
    localparam int B_PIE_BIT = 6;
    localparam int B_SET_BIT = 7;
    localparam int C_UF_BIT = 4;                    // update_done_flag
    localparam int C_AF_BIT = 5;                    // alarm_flag
    localparam int C_PF_BIT = 6;                    // periodic_flag
    localparam int C_IRQF_BIT = 7;
    localparam int D_VALID_BIT = 7;                 // ram_time_valid_flag

    // ==========================================================
    // Values after reset and encodings
    // ==========================================================
    localparam logic [2:0] DIV_RUN = 3'h2;          // Only pattern that keeps time
    localparam logic [1:0] DIV_HOLD_TOP = 2'h3;     // 11X holds chain; oscRunning stays low
    localparam logic [2:0] DIV_RESET_VAL = 3'h0;
    localparam logic [3:0] RATE_RESET_VAL = 4'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ==========================================================
    // Carriers
    // ==========================================================
    // Parallel bus pins, all active low strobes
    typedef struct packed {
        logic csN;                                  // Clock register select
        logic rdN;                                  // Read strobe
        logic wrN;                                  // Write strobe
        logic [5:0] addr;                           // Register address
    } rtcv_bus_s;

    // Whole state of the register bank
    typedef struct packed {
        logic rdPrev;                               // Synced read strobe last cycle
        logic wrPrev;                               // Synced write strobe last cycle
        logic [5:0] rdAddr;                         // Address caught at read start
        logic [2:0] divider;                        // divider_control_bits
        logic [3:0] rate;                           // rate_select_bits
        logic [7:0] ctrlB;                          // Enables and modes
        logic periodicFlag;
        logic alarmFlag;
        logic updateDoneFlag;
        logic irqActive;                            // Drives interrupt pin low
        logic oscRunning;
        logic chainHold;
        logic [7:0] readData;
        logic dataOe;
    } rtcv_state_s;

endpackage

// [verilog/rtcv_sync.sv]
`timescale 1ns/10ps
// ==========================================================
// Two-flop synchroniser for a vector of pin inputs
// ==========================================================
module rtcv_sync import rtcv_pkg::*; #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    // First and later stages; each is read only by the next stage, the last one by syncOut
    logic [WIDTH-1:0] stage_q [SYNC_STAGES];

    genvar s;
    generate
        for (s = 0; s < SYNC_STAGES; s++) begin : g_stage
            // Stage zero samples the input, each later stage samples the one before it
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    stage_q[s] <= INIT;
                end else if (s == 0) begin
                    stage_q[s] <= asyncIn;
                end else begin
                    stage_q[s] <= stage_q[(s == 0) ? 0 : s - 1];
                end
            end
        end
    endgenerate

    assign syncOut = stage_q[SYNC_STAGES-1];
endmodule

// [verilog/rtcv_status_bank.sv]
`timescale 1ns/10ps
// Overview of operation
// - Valid flag reads one while backup healthy
// - Host writes never change valid flag
// - Valid flag reads zero once source exhausted
// - Bits six to zero always read zero
// - Writes to reserved status bits are discarded
// - Oscillator runs within one second of enable
// - Interrupt released soon after read strobe rises
// - Interrupt released soon after reset pin low
// - Flag read or reset pin clears flags
// - Only divider pattern 010 keeps time
// - Registers accessible anytime, even during update
module rtcv_status_bank import rtcv_pkg::*; (
    input wire logic clock,
    input wire logic reset_n,
    input wire rtcv_bus_s busPins,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic dataOe,
    output logic irqOut,
    output logic irqOe,
    input wire logic resetPinN,
    input wire logic backupGood,
    input wire logic updateBusy,
    input wire logic periodicTick,
    input wire logic alarmMatch,
    input wire logic updateDone,
    output logic oscRunning,
    output logic chainHold,
    output logic [3:0] rateSelect,
    output logic [7:0] modeBits
);
    // ==========================================================
    // Pin synchronisation
    // ==========================================================
    localparam int PIN_W = $bits(rtcv_bus_s) + 10;
    localparam logic [PIN_W-1:0] PIN_IDLE = {1'b1, 1'b1, 1'b1, 6'h00, 8'h00, 1'b1, 1'b0};

    logic [PIN_W-1:0] pinSync;                      // All pins after two flops
    rtcv_bus_s busS;                                // Synced strobes and address
    logic [7:0] dataS;                              // Synced write data
    logic resetPinS;                                // Synced reset pin, active low
    logic backupS;                                  // Synced backup health

    // Data is synced with the same latency as the write strobe so the
    // setup window before the strobe rise is kept after the crossing
    rtcv_sync #(
        .WIDTH(PIN_W),
        .INIT(PIN_IDLE)
    ) u_sync (
        .clock(clock),
        .reset_n(reset_n),
        .asyncIn({busPins, dataIn, resetPinN, backupGood}),
        .syncOut(pinSync)
    );

    assign busS = pinSync[PIN_W-1 -: $bits(rtcv_bus_s)];
    assign dataS = pinSync[9:2];
    assign resetPinS = pinSync[1];
    assign backupS = pinSync[0];

    // ==========================================================
    // Read value decode
    // ==========================================================
    // Builds the byte seen on a read of the given offset
    function automatic logic [7:0] read_value(
        input logic [5:0] addr,
        input rtcv_state_s st,
        input logic backup
    );
        logic [7:0] v;
        v = BYTE_ZERO;
        case (addr)
            OFS_CTRL_A: begin
                v[A_DIV_LSB +: 3] = st.divider;
                v[A_RATE_LSB +: 4] = st.rate;
                v[7] = updateBusy;
            end
            OFS_CTRL_B: begin
                v = st.ctrlB;
            end
            OFS_FLAGS: begin
                v[C_IRQF_BIT] = st.irqActive;
                v[C_PF_BIT] = st.periodicFlag;
                v[C_AF_BIT] = st.alarmFlag;
                v[C_UF_BIT] = st.updateDoneFlag;
            end
            OFS_BATTERY_VALID_STATUS: begin
                // Only the top bit carries state, the rest stays zero
                v[D_VALID_BIT] = backup;
            end
            default: begin
                v = BYTE_ZERO;
            end
        endcase
        return v;
    endfunction

    // ==========================================================
    // State update
    // ==========================================================
    rtcv_state_s state_q;                           // Registered state
    rtcv_state_s state_d;                           // Next state

    logic selected;                                 // Register select active
    logic rdStart;                                  // Read strobe fell
    logic rdEnd;                                    // Read strobe rose
    logic wrEnd;                                    // Write strobe rose
    logic flagsRead;                                // Read of flags register ended
    logic pinReset;                                 // Reset pin held low
    logic irqNext;                                  // Interrupt condition

    // Strobe edges are taken on synced levels only
    assign selected = !busS.csN;
    assign rdStart = state_q.rdPrev && !busS.rdN && selected;
    assign rdEnd = !state_q.rdPrev && busS.rdN;
    assign wrEnd = !state_q.wrPrev && busS.wrN && selected;
    assign flagsRead = rdEnd && (state_q.rdAddr == OFS_FLAGS); // Status reads never clear
    assign pinReset = !resetPinS;

    // Next state of the whole bank
    always_comb begin
        state_d = state_q;
        state_d.rdPrev = busS.rdN;
        state_d.wrPrev = busS.wrN;

        // Accesses are never held off by an update in progress
        if (rdStart) begin
            state_d.rdAddr = busS.addr;
            state_d.readData = read_value(busS.addr, state_q, backupS);
        end
        // Data drive follows the synced strobe and select
        state_d.dataOe = !busS.rdN && selected;

        // Writes reach only the two control registers; status writes
        // fall through the default branch and are dropped
        if (wrEnd) begin
            case (busS.addr)
                OFS_CTRL_A: begin
                    state_d.divider = dataS[A_DIV_LSB +: 3];
                    state_d.rate = dataS[A_RATE_LSB +: 4];
                end
                OFS_CTRL_B: begin
                    state_d.ctrlB = dataS;
                    // Raising the set bit clears the update enable
                    if (dataS[B_SET_BIT]) begin
                        state_d.ctrlB[B_UIE_BIT] = 1'b0;
                    end
                end
                default: begin
                    state_d.ctrlB = state_q.ctrlB;
                end
            endcase
        end

        // Reset pin clears the interrupt enables and square wave enable
        if (pinReset) begin
            state_d.ctrlB[B_PIE_BIT] = 1'b0;
            state_d.ctrlB[B_AIE_BIT] = 1'b0;
            state_d.ctrlB[B_UIE_BIT] = 1'b0;
            state_d.ctrlB[B_SQWE_BIT] = 1'b0;
        end

        // Flag clear on read end; an event in the same cycle still sets
        // its flag. The reset pin is a held level, so it dominates.
        if (pinReset) begin
            state_d.periodicFlag = 1'b0;
            state_d.alarmFlag = 1'b0;
            state_d.updateDoneFlag = 1'b0;
        end else begin
            state_d.periodicFlag = (state_q.periodicFlag && !flagsRead) || periodicTick;
            state_d.alarmFlag = (state_q.alarmFlag && !flagsRead) || alarmMatch;
            state_d.updateDoneFlag = (state_q.updateDoneFlag && !flagsRead) || updateDone;
        end

        // Interrupt is built from the next gated flags, so it moves in the same cycle as the flags, which keeps
        // the release well inside the allowed window
        irqNext = (state_d.periodicFlag && state_d.ctrlB[B_PIE_BIT])
                  || (state_d.alarmFlag && state_d.ctrlB[B_AIE_BIT])
                  || (state_d.updateDoneFlag && state_d.ctrlB[B_UIE_BIT]);
        state_d.irqActive = irqNext;

        // Divider pattern decode; the run output is a cycle after the
        // write, far below the start-up limit
        state_d.oscRunning = (state_d.divider == DIV_RUN);
        state_d.chainHold = (state_d.divider[2:1] == DIV_HOLD_TOP);
    end

    // Register the state; only reset loads constants
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '{
                rdPrev: 1'b1,
                wrPrev: 1'b1,
                rdAddr: 6'h00,
                divider: DIV_RESET_VAL,
                rate: RATE_RESET_VAL,
                ctrlB: BYTE_ZERO,
                periodicFlag: 1'b0,
                alarmFlag: 1'b0,
                updateDoneFlag: 1'b0,
                irqActive: 1'b0,
                oscRunning: 1'b0,
                chainHold: 1'b0,
                readData: BYTE_ZERO,
                dataOe: 1'b0
            };
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // Reads of the status byte touch no flag; only flagsRead and the reset pin clear
    assign dataOut = state_q.readData;
    assign dataOe = state_q.dataOe;
    // Open-drain interrupt: only ever pulled low
    assign irqOut = 1'b0;
    assign irqOe = state_q.irqActive;
    assign oscRunning = state_q.oscRunning;
    assign chainHold = state_q.chainHold;
    assign rateSelect = state_q.rate;
    assign modeBits = state_q.ctrlB;
endmodule

// [tb/rtcv_status_bank_props.sv]
`timescale 1ns/10ps
// ==========================================================
// Port checker for the status bank
// ==========================================================
module rtcv_status_bank_props import rtcv_pkg::*; (
    input wire logic clock,
    input wire logic reset_n,
    input wire rtcv_bus_s busPins,
    input wire logic [7:0] dataIn,
    input wire logic [7:0] dataOut,
    input wire logic dataOe,
    input wire logic irqOe,
    input wire logic resetPinN,
    input wire logic backupGood,
    input wire logic periodicTick,
    input wire logic alarmMatch,
    input wire logic updateDone,
    input wire logic oscRunning,
    input wire logic chainHold,
    input wire logic [3:0] rateSelect,
    input wire logic [7:0] modeBits
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // No event, write or reset pin that could move a flag
    logic quiet;
    assign quiet = !periodicTick && !alarmMatch && !updateDone && busPins.wrN && resetPinN;
    // Status read held steady long enough for the answer
    sequence statusRead;
        $fell(busPins.rdN) && !busPins.csN && busPins.addr == OFS_BATTERY_VALID_STATUS && quiet ##1
        (!busPins.rdN && !busPins.csN && busPins.addr == OFS_BATTERY_VALID_STATUS && quiet)[*2];
    endsequence
    // Write strobe rising on a given offset
    sequence wrAt(logic [5:0] a);
        $rose(busPins.wrN) && !busPins.csN && busPins.addr == a;
    endsequence
    a_status_low_zero: assert property (statusRead |=> dataOe && dataOut[6:0] == 7'h00)
        else $error("status reserved bits not zero");
    a_valid_follows_src: assert property (statusRead |=> dataOut[7] == backupGood)
        else $error("valid flag does not follow backup source");
    a_status_no_side: assert property (statusRead ##1 quiet[*2] |=> irqOe == $past(irqOe, 3))
        else $error("status read moved the interrupt");
    a_irq_rd_release: assert property ($rose(busPins.rdN) && !busPins.csN
        && busPins.addr == OFS_FLAGS && quiet ##1 quiet[*4] |=> !irqOe)
        else $error("interrupt not released after flag read");
    a_irq_rst_release: assert property ($fell(resetPinN) ##1 !resetPinN[*4] |=> !irqOe)
        else $error("interrupt not released after reset pin");
    a_osc_pattern_only: assert property (wrAt(OFS_CTRL_A) |-> ##4
        oscRunning == (dataIn[6:4] == DIV_RUN) && chainHold == (dataIn[6:5] == DIV_HOLD_TOP))
        else $error("oscillator state wrong after divider write");
    a_rate_write_any: assert property (wrAt(OFS_CTRL_A) |-> ##3 rateSelect == dataIn[3:0])
        else $error("rate select not taken");
    a_status_wr_ignored: assert property (wrAt(OFS_BATTERY_VALID_STATUS) |=>
        ($stable(rateSelect) && $stable(modeBits) && $stable(oscRunning))[*4])
        else $error("status write changed state");
    c_status_read: cover property (statusRead);
    c_irq_drop: cover property ($fell(irqOe));
    c_osc_run: cover property ($rose(oscRunning));
endmodule

bind rtcv_status_bank rtcv_status_bank_props u_props (.clock(clock), .reset_n(reset_n), .busPins(busPins),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .irqOe(irqOe), .resetPinN(resetPinN),
    .backupGood(backupGood), .periodicTick(periodicTick), .alarmMatch(alarmMatch), .updateDone(updateDone),
    .oscRunning(oscRunning), .chainHold(chainHold), .rateSelect(rateSelect), .modeBits(modeBits));

// [tb/rtcv_host_model.sv]
`timescale 1ns/10ps
// ==========================================================
// Host processor on the parallel strobe bus
// ==========================================================
module rtcv_host_model import rtcv_pkg::*; (
    input wire logic clock,
    input wire logic [7:0] dataOut,
    input wire logic dataOe,
    output rtcv_bus_s busPins,
    output logic [7:0] dataIn
);
    // Idle bus, strobes high
    initial begin
        busPins = '{csN: 1'b1, rdN: 1'b1, wrN: 1'b1, addr: 6'h00};
        dataIn = 8'h00;
    end
    // Strobe held four clocks so the synced answer has landed
    task automatic busRead(input logic [5:0] a, output logic [7:0] d);
        @(negedge clock);
        busPins.csN = 1'b0;
        busPins.addr = a;
        busPins.rdN = 1'b0;
        repeat (4) @(posedge clock);
        @(negedge clock);
        // Taken off the clock edge, where the answer has settled;
        // undriven data lines give an unknown, so a missing answer fails
        d = (dataOe === 1'b1) ? dataOut : 8'hxx;
        busPins.rdN = 1'b1;
        repeat (4) @(negedge clock);
        busPins.csN = 1'b1;
        busPins.addr = ~a;
        repeat (2) @(negedge clock);
    endtask
    // Data held past the update so the latched byte is unambiguous
    task automatic busWrite(input logic [5:0] a, input logic [7:0] d);
        @(negedge clock);
        busPins.csN = 1'b0;
        busPins.addr = a;
        dataIn = d;
        busPins.wrN = 1'b0;
        repeat (4) @(negedge clock);
        busPins.wrN = 1'b1;
        repeat (5) @(negedge clock);
        busPins.csN = 1'b1;
        dataIn = ~d;
        busPins.addr = ~a;
        @(negedge clock);
    endtask
endmodule

// [tb/tb_rtcv_status_bank.sv]
`timescale 1ns/10ps
// ==========================================================
// Self-checking bench for the status bank
// ==========================================================
module tb_rtcv_status_bank import rtcv_pkg::*; ;
    logic clock, reset_n, dataOe, irqOut, irqOe, resetPinN, backupGood, updateBusy;
    logic periodicTick, alarmMatch, updateDone, oscRunning, chainHold;
    logic [7:0] dataIn, dataOut, modeBits, rd;
    logic [3:0] rateSelect, r;
    rtcv_bus_s busPins;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    rtcv_host_model host (.clock(clock), .dataOut(dataOut), .dataOe(dataOe), .busPins(busPins), .dataIn(dataIn));
    rtcv_status_bank dut (.clock(clock), .reset_n(reset_n), .busPins(busPins), .dataIn(dataIn),
        .dataOut(dataOut), .dataOe(dataOe), .irqOut(irqOut), .irqOe(irqOe), .resetPinN(resetPinN),
        .backupGood(backupGood), .updateBusy(updateBusy), .periodicTick(periodicTick),
        .alarmMatch(alarmMatch), .updateDone(updateDone), .oscRunning(oscRunning),
        .chainHold(chainHold), .rateSelect(rateSelect), .modeBits(modeBits));
    always #10 clock = ~clock;
    // Hang guard, far above the under one thousand cycles the run needs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // One-cycle event pulse: 0 periodic, 1 alarm, 2 update done
    task automatic pulseEvent(input int which);
        @(negedge clock);
        periodicTick = (which == 0);
        alarmMatch = (which == 1);
        updateDone = (which == 2);
        @(negedge clock);
        {periodicTick, alarmMatch, updateDone} = 3'h0;
        repeat (4) @(negedge clock);
    endtask
    // Flag byte after one event with all enables on
    function automatic logic [7:0] expFlags(int ev);
        return {1'b1, ev == 0, ev == 1, ev == 2, 4'h0};
    endfunction
    initial begin
        {clock, reset_n, updateBusy, periodicTick, alarmMatch, updateDone} = 6'h00;
        {resetPinN, backupGood} = 2'h3;
        void'($urandom(32'hbc06_af13));
        repeat (2) @(posedge clock);
        @(negedge clock) reset_n = 1'b1;
        check("mode after reset", modeBits, 8'h00);
        check("flags after reset", {oscRunning, chainHold, dataOe, irqOe, rateSelect}, 8'h00);
        // Source health both ways, then writes that must be dropped
        for (int i = 0; i < 6; i++) begin
            backupGood = (i < 2) ? i[0] : 1'($urandom);
            repeat (4) @(negedge clock);
            host.busRead(OFS_BATTERY_VALID_STATUS, rd);
            check("status", rd, {backupGood, 7'h00});
            host.busWrite(OFS_BATTERY_VALID_STATUS, 8'($urandom));
            host.busRead(OFS_BATTERY_VALID_STATUS, rd);
            check("status after write", rd, {backupGood, 7'h00});
        end
        // Every divider pattern, some during an update
        for (int p = 0; p < 8; p++) begin
            r = 4'($urandom);
            updateBusy = 1'($urandom);
            host.busWrite(OFS_CTRL_A, {1'b0, 3'(p), r});
            check("osc", {7'h00, oscRunning}, {7'h00, p == 2});
            check("hold", {7'h00, chainHold}, {7'h00, p >= 6});
            host.busRead(OFS_CTRL_A, rd);
            check("ctrl a", rd, {updateBusy, 3'(p), r});
        end
        updateBusy = 1'b0;
        // Set bit written with all enables drops the update enable
        host.busWrite(OFS_CTRL_B, 8'hF0);
        check("set clears update enable", modeBits, 8'hE0);
        // Each interrupt source raised, survives a status read, cleared by flag read
        for (int ev = 0; ev < 3; ev++) begin
            host.busWrite(OFS_CTRL_B, 8'h70);
            pulseEvent(ev);
            check("irq raised", {7'h00, irqOe}, 8'h01);
            host.busRead(OFS_BATTERY_VALID_STATUS, rd);
            check("irq after status read", {7'h00, irqOe}, 8'h01);
            host.busRead(OFS_FLAGS, rd);
            check("flags", rd, expFlags(ev));
            check("irq after flag read", {7'h00, irqOe}, 8'h00);
            host.busRead(OFS_FLAGS, rd);
            check("flags cleared", rd, 8'h00);
        end
        // Reset pin drops a pending interrupt and its flag
        pulseEvent(1);
        check("irq raised", {7'h00, irqOe}, 8'h01);
        resetPinN = 1'b0;
        repeat (IRQ_RELEASE_RST_CYC) @(negedge clock);
        check("irq under reset pin", {7'h00, irqOe}, 8'h00);
        check("mode under reset pin", modeBits, 8'h00);
        resetPinN = 1'b1;
        repeat (4) @(negedge clock);
        host.busRead(OFS_FLAGS, rd);
        check("flags after reset pin", rd, 8'h00);
        finish_test();
    end
endmodule
